// ==== input_frame_offset_control.sv ====
// Per-stream input frame offset registers and frame-start timing for 64 streams
// What this block does
// - Holds a 4-bit offset field per stream 0..63, four to a 16-bit register, stream k in nibble k mod 4 of register k/4, whole bits above the half bit.
// - The three whole-clock bits set how many serial clocks after the frame pulse bit 0 of a new frame is taken.
// - A half select of 0 puts the frame start on a serial clock boundary, 1 moves it half a clock off it.
// - The total offset is the whole value plus half a clock when selected, sixteen steps from 0 to 7.5 clocks.
// - An all-zero field means no shift and is the reset value of every stream.
// - A rising start bit begins a delay measurement, completion ends it, and the bit must sit at zero a frame before the next start.
`timescale 1ns/1ps
`default_nettype none

module input_frame_offset_control
    import frame_offset_pkg::*;
#(
    parameter int SERIAL_DIV = 2,
    parameter int COUNT_WIDTH = 8
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Frame timing
    input wire logic frame_pulse_input,
    input wire logic eval_complete,
    output logic [STREAM_COUNT-1:0] frame_start,
    output logic measure_active
);

    // ************************************************************
    // Offset arithmetic
    // ************************************************************
    localparam int HALF_STEP = SERIAL_DIV / 2;
    localparam int LAST_COUNT = (1 << WHOLE_WIDTH) * SERIAL_DIV;

    function automatic offset_field_t field_of(input logic [OFFSET_REG_WIDTH-1:0] r,
                                               input int slot);
        offset_field_t f;
        f = offset_field_t'(r[slot*FIELD_WIDTH +: FIELD_WIDTH]);
        return f;
    endfunction

    // Cycles from the frame pulse to frame start for one field
    function automatic logic [COUNT_WIDTH-1:0] target_of(input offset_field_t f);
        logic [COUNT_WIDTH-1:0] t;
        t = COUNT_WIDTH'(int'(f.whole) * SERIAL_DIV);
        if (f.half)
        begin
            t = t + COUNT_WIDTH'(HALF_STEP);
        end
        return t;
    endfunction

    // ************************************************************
    // Registers
    // ************************************************************
    logic [OFFSET_REG_WIDTH-1:0] offset_reg [OFFSET_REG_COUNT];
    logic [OFFSET_REG_WIDTH-1:0] shadow_reg [OFFSET_REG_COUNT];
    bus_request_t request_reg;
    bus_request_t request_next;
    logic start_bit_reg;
    logic start_prev_reg;
    logic complete_prev_reg;
    logic frame_seen_reg;
    measure_state_t measure_reg;
    measure_state_t measure_next;
    logic [COUNT_WIDTH-1:0] count_reg;
    logic counting_reg;
    logic [31:0] hrdata_next;

    // ************************************************************
    // Address decode
    // ************************************************************
    wire logic addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    wire logic [3:0] rd_index = haddr[5:2];
    wire logic rd_offset_hit = (haddr[31:6] == OFFSET_BASE_ADDR[31:6]) && (haddr[1:0] == 2'h0);
    wire logic rd_control_hit = (haddr == CONTROL_ADDR);
    wire logic rd_status_hit = (haddr == STATUS_ADDR);
    wire logic [3:0] wr_index = request_reg.addr[5:2];
    wire logic wr_go = request_reg.valid && request_reg.write;
    wire logic wr_offset_hit = wr_go && (request_reg.addr[31:6] == OFFSET_BASE_ADDR[31:6])
                               && (request_reg.addr[1:0] == 2'h0);
    wire logic wr_control_hit = wr_go && (request_reg.addr == CONTROL_ADDR);

    // ************************************************************
    // Read data, taken in the address phase
    // ************************************************************
    wire logic [31:0] status_word = {29'h0, frame_seen_reg, measure_reg == MEAS_RUNNING,
                                     measure_reg == MEAS_ARMED};
    wire logic [31:0] control_word = {31'h0, start_bit_reg};
    wire logic [31:0] offset_word = {16'h0, offset_reg[rd_index]};

    assign hrdata_next = !(addr_phase && !hwrite) ? DATA_ZERO :
                         rd_offset_hit ? offset_word :
                         rd_control_hit ? control_word :
                         rd_status_hit ? status_word : DATA_ZERO;

    assign request_next = '{valid: addr_phase, write: hwrite, addr: haddr};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            request_reg <= '0;
            hrdata <= DATA_ZERO;
            hreadyout <= 1'b0;
            hresp <= HRESP_OKAY;
        end
        else
        begin
            request_reg <= request_next;
            hrdata <= hrdata_next;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    // ************************************************************
    // Offset registers and frame-aligned shadow copies
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < OFFSET_REG_COUNT; i++)
            begin
                offset_reg[i] <= OFFSET_RESET;
                shadow_reg[i] <= OFFSET_RESET;
            end
        end
        else
        begin
            if (wr_offset_hit)
            begin
                offset_reg[wr_index] <= hwdata[OFFSET_REG_WIDTH-1:0];
            end
            if (frame_pulse_input)
            begin
                for (int i = 0; i < OFFSET_REG_COUNT; i++)
                begin
                    shadow_reg[i] <= offset_reg[i];
                end
            end
        end
    end

    // ************************************************************
    // Frame counter, restarted by each frame pulse
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count_reg <= '0;
            counting_reg <= 1'b0;
        end
        else if (frame_pulse_input)
        begin
            count_reg <= '0;
            counting_reg <= 1'b1;
        end
        else if (counting_reg)
        begin
            count_reg <= count_reg + COUNT_WIDTH'(1);
            counting_reg <= (count_reg != COUNT_WIDTH'(LAST_COUNT));
        end
    end

    // ************************************************************
    // Per-stream frame start strobes
    // ************************************************************
    logic [STREAM_COUNT-1:0] start_hit;

    always_comb
    begin
        for (int k = 0; k < STREAM_COUNT; k++)
        begin
            start_hit[k] = counting_reg &&
                (count_reg == target_of(field_of(shadow_reg[k / FIELDS_PER_REG],
                                                 k % FIELDS_PER_REG)));
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            frame_start <= '0;
        end
        else
        begin
            frame_start <= start_hit;
        end
    end

    // ************************************************************
    // Delay measurement control
    // ************************************************************
    wire logic start_rise = start_bit_reg && !start_prev_reg;
    wire logic complete_rise = eval_complete && !complete_prev_reg;

    always_comb
    begin
        measure_next = measure_reg;
        unique case (measure_reg)
            MEAS_DISARMED:
            begin
                if (frame_pulse_input && !start_bit_reg)
                begin
                    measure_next = MEAS_ARMED;
                end
            end
            MEAS_ARMED:
            begin
                if (start_rise)
                begin
                    measure_next = MEAS_RUNNING;
                end
            end
            MEAS_RUNNING:
            begin
                if (complete_rise)
                begin
                    measure_next = MEAS_DISARMED;
                end
            end
            default:
            begin
                measure_next = MEAS_DISARMED;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            start_bit_reg <= 1'b0;
            start_prev_reg <= 1'b0;
            complete_prev_reg <= 1'b0;
            frame_seen_reg <= 1'b0;
            measure_reg <= MEAS_DISARMED;
            measure_active <= 1'b0;
        end
        else
        begin
            if (wr_control_hit)
            begin
                start_bit_reg <= hwdata[CTRL_START_POS];
            end
            start_prev_reg <= start_bit_reg;
            complete_prev_reg <= eval_complete;
            if (frame_pulse_input)
            begin
                frame_seen_reg <= 1'b1;
            end
            measure_reg <= measure_next;
            measure_active <= (measure_next == MEAS_RUNNING);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking chk_clk @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic [OFFSET_REG_WIDTH-1:0] pending_reg;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pending_reg <= OFFSET_RESET;
        end
        else
        begin
            pending_reg <= offset_reg[0];
        end
    end

    field_write_a: assert property (wr_offset_hit |=>
        offset_reg[$past(wr_index)] == $past(hwdata[OFFSET_REG_WIDTH-1:0]))
        else $error("offset register did not take written word");

    zero_offset_a: assert property ($rose(counting_reg) && shadow_reg[0][3:0] == 4'h0
        && !frame_pulse_input |=> frame_start[0])
        else $error("zero offset stream 0 did not start with the pulse");

    whole_delay_a: assert property ($rose(counting_reg) && shadow_reg[0][3:0] == 4'h2
        && !frame_pulse_input[*1] ##1 !frame_pulse_input[*2]
        |-> frame_start[0] == 1'b0 ##1 frame_start[0])
        else $error("whole offset one did not land after one serial clock");

    half_delay_a: assert property ($rose(counting_reg) && shadow_reg[1][3:0] == 4'h1
        && !frame_pulse_input ##1 !frame_pulse_input |-> ##1 frame_start[4])
        else $error("half offset did not land half a clock late");

    max_offset_a: assert property (start_hit[63] |->
        count_reg == COUNT_WIDTH'(shadow_reg[15][15:13]) * COUNT_WIDTH'(SERIAL_DIV)
        + (shadow_reg[15][12] ? COUNT_WIDTH'(HALF_STEP) : COUNT_WIDTH'(0)))
        else $error("stream 63 started at wrong count");

    shadow_load_a: assert property (frame_pulse_input |=> shadow_reg[0] == pending_reg)
        else $error("shadow offsets not loaded at the frame pulse");

    frame_apply_a: assert property (!frame_pulse_input |=> shadow_reg[0] == $past(shadow_reg[0]))
        else $error("offset applied outside a frame boundary");

    measure_start_a: assert property (measure_reg == MEAS_ARMED && start_rise
        |=> measure_active ##0 measure_reg == MEAS_RUNNING)
        else $error("measurement did not start on rising start bit");

    measure_stop_a: assert property (measure_reg == MEAS_RUNNING && complete_rise
        |=> !measure_active)
        else $error("measurement did not stop on completion");

    rearm_need_a: assert property (measure_reg == MEAS_DISARMED
        && !(frame_pulse_input && !start_bit_reg) |=> measure_reg == MEAS_DISARMED)
        else $error("measurement restarted without a frame at zero");

    bus_okay_a: assert property (request_reg.valid |-> hreadyout && hresp == HRESP_OKAY)
        else $error("bus answer not ready okay");

    measure_run_c: cover property (measure_reg == MEAS_RUNNING ##[1:50] !measure_active);
    late_start_c: cover property (frame_start[63] && count_reg == COUNT_WIDTH'(LAST_COUNT));
    reprogram_c: cover property (wr_offset_hit ##[1:50] frame_pulse_input);
    half_start_c: cover property (frame_start[4] && shadow_reg[1][HALF_BIT_POS]);

endmodule

`default_nettype wire

// ==== frame_offset_pkg.sv ====
// Constants, field layouts and carrier types for the input frame offset block
package frame_offset_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [31:0] OFFSET_BASE_ADDR = 32'h0000_0000;
    localparam logic [31:0] CONTROL_ADDR = 32'h0000_0040;
    localparam logic [31:0] STATUS_ADDR = 32'h0000_0044;
    localparam int OFFSET_REG_COUNT = 16;
    localparam int OFFSET_REG_WIDTH = 16;
    localparam int STREAM_COUNT = 64;
    localparam logic [15:0] OFFSET_RESET = 16'h0000;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    // ************************************************************
    // Offset field layout inside a register
    // ************************************************************
    localparam int FIELD_WIDTH = 4;
    localparam int FIELDS_PER_REG = 4;
    localparam int HALF_BIT_POS = 0;
    localparam int WHOLE_LSB = 1;
    localparam int WHOLE_WIDTH = 3;

    // ************************************************************
    // Control and status bits
    // ************************************************************
    localparam int CTRL_START_POS = 0;
    localparam int STAT_ARMED_POS = 0;
    localparam int STAT_RUNNING_POS = 1;
    localparam int STAT_FRAME_POS = 2;

    // ************************************************************
    // Bus encodings
    // ************************************************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'h0;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic [2:0] whole;
        logic half;
    } offset_field_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
    } bus_request_t;

    typedef enum logic [1:0] {
        MEAS_DISARMED,
        MEAS_ARMED,
        MEAS_RUNNING
    } measure_state_t;

endpackage

// ==== frame_source.sv ====
// Frame pulse and completion flag source facing the offset block
`timescale 1ns/1ps
`default_nettype none

module frame_source (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bench control
    input wire logic [7:0] frame_len,
    input wire logic [7:0] eval_delay,
    // Block side
    input wire logic measure_active,
    output logic frame_pulse_input,
    output logic eval_complete
);
    int frame_cnt;
    int eval_cnt;

    // ********
    // One-cycle pulse each frame, stopped while frame_len is zero
    // ********
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            frame_cnt <= 0;
            eval_cnt <= 0;
            frame_pulse_input <= 1'b0;
            eval_complete <= 1'b0;
        end
        else
        begin
            frame_pulse_input <= (frame_len != 8'h00) && (frame_cnt == 0);
            frame_cnt <= (frame_cnt + 1 >= int'(frame_len)) ? 0 : frame_cnt + 1;
            eval_cnt <= measure_active ? eval_cnt + 1 : 0;
            eval_complete <= measure_active && (eval_cnt >= int'(eval_delay));
        end
    end
endmodule

`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the input frame offset block
`timescale 1ns/1ps
`default_nettype none

module tb;
    import frame_offset_pkg::*;
    // ********
    // Signals and model state
    // ********
    localparam int SD = 2;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [7:0] frame_len = 8'h00;
    logic [7:0] eval_delay = 8'h06;
    wire logic hreadyout, hresp, frame_pulse_input, eval_complete, measure_active;
    wire logic [31:0] hrdata;
    wire logic [63:0] frame_start;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    int cnt = 1000;
    logic [15:0] mdl [16] = '{default: 16'h0000};
    logic [15:0] shadow [16] = '{default: 16'h0000};
    logic [63:0] exp_fs;
    logic [31:0] rnd = 32'h0000_6192;
    logic [31:0] rd;
    logic [15:0] v;

    always #5 hclk = ~hclk;

    input_frame_offset_control #(.SERIAL_DIV(SD)) input_frame_offset_control_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .frame_pulse_input(frame_pulse_input), .eval_complete(eval_complete),
        .frame_start(frame_start), .measure_active(measure_active));

    frame_source frame_source_inst (
        .hclk(hclk), .hresetn(hresetn), .frame_len(frame_len), .eval_delay(eval_delay),
        .measure_active(measure_active), .frame_pulse_input(frame_pulse_input),
        .eval_complete(eval_complete));

    // ********
    // Checks, helpers and bus cycles
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk64(input logic [63:0] got, input logic [63:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'h8020_0003 : 32'h0000_0000);
    endfunction

    // Field from a measurement: delay bits copied, half flag inverted
    function automatic logic [3:0] from_measure(input logic half_flag, input logic [2:0] dly);
        return {dly, ~half_flag};
    endfunction

    function automatic int target(input logic [3:0] f);
        // Strobe is launched one edge after the pulse and seen one edge later
        return 2 + int'(f[3:1]) * SD + int'(f[0]) * (SD / 2);
    endfunction

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk(hresp, HRESP_OKAY, "response");
        if (wr && a < CONTROL_ADDR)
            mdl[a[5:2]] <= wd[15:0];
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string msg);
        bus(1'b0, a, DATA_ZERO);
        chk(rd, exp, msg);
    endtask

    task automatic finish_test;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Frame start strobes against offsets latched at each pulse
    always @(posedge hclk)
    begin
        if (hresetn !== 1'b1)
            cnt = 1000;
        else
        begin
            if (cnt < 1000)
                cnt = cnt + 1;
            for (int k = 0; k < 64; k++)
                exp_fs[k] = (cnt == target(shadow[k / 4][4 * (k % 4) +: 4]));
            chk64(frame_start, exp_fs, "frame start");
            if (frame_pulse_input === 1'b1)
            begin
                shadow = mdl;
                cnt = 0;
            end
        end
    end

    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            finish_test();
        end
    end

    // ********
    // Main sequence
    // ********
    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        for (int i = 0; i < 16; i++)
            rdchk(OFFSET_BASE_ADDR + 4 * i, DATA_ZERO, "reset value");
        for (int i = 0; i < 16; i++)
        begin
            rnd = lfsr(rnd);
            bus(1'b1, OFFSET_BASE_ADDR + 4 * i, rnd);
            rdchk(OFFSET_BASE_ADDR + 4 * i, {16'h0000, rnd[15:0]}, "readback");
        end
        bus(1'b1, 32'h0000_0048, 32'hffff_ffff);
        rdchk(32'h0000_0048, DATA_ZERO, "unmapped");
        $display("test registers done");
        frame_len <= 8'd24;
        for (int i = 0; i < 16; i++)
            bus(1'b1, OFFSET_BASE_ADDR + 4 * i,
                {16'h0000, 4'(4 * i + 3), 4'(4 * i + 2), 4'(4 * i + 1), 4'(4 * i)});
        repeat (60) @(posedge hclk);
        $display("test all codes done");
        repeat (40)
        begin
            rnd = lfsr(rnd);
            for (int j = 0; j < 4; j++)
                v[4 * j +: 4] = from_measure(rnd[16 + 4 * j], rnd[17 + 4 * j +: 3]);
            bus(1'b1, OFFSET_BASE_ADDR + 4 * rnd[3:0], {16'h0000, v});
            repeat (rnd[9:5]) @(posedge hclk);
        end
        $display("test mid-frame writes done");
        bus(1'b1, CONTROL_ADDR, DATA_ZERO);
        repeat (30) @(posedge hclk);
        bus(1'b1, CONTROL_ADDR, 32'h0000_0001);
        @(posedge hclk);
        chk(measure_active, 1'b0, "early start");
        @(posedge hclk);
        chk(measure_active, 1'b1, "start");
        bus(1'b0, STATUS_ADDR, DATA_ZERO);
        chk(rd & 32'h0000_0002, 32'h0000_0002, "running");
        for (int n = 0; n < 300 && eval_complete !== 1'b1; n++)
            @(posedge hclk);
        @(posedge hclk);
        chk(measure_active, 1'b0, "stop");
        frame_len <= 8'h00;
        bus(1'b1, CONTROL_ADDR, DATA_ZERO);
        bus(1'b1, CONTROL_ADDR, 32'h0000_0001);
        repeat (10) @(posedge hclk);
        chk(measure_active, 1'b0, "no frame gap");
        frame_len <= 8'd24;
        bus(1'b1, CONTROL_ADDR, DATA_ZERO);
        repeat (30) @(posedge hclk);
        bus(1'b1, CONTROL_ADDR, 32'h0000_0001);
        repeat (3) @(posedge hclk);
        chk(measure_active, 1'b1, "restart");
        repeat (40) @(posedge hclk);
        $display("test measurement done");
        finish_test();
    end
endmodule

`default_nettype wire
